// >>> hw/tmcc_consts.svh
// Register offsets, field positions, reset values for the timer block
`ifndef TMCC_CONSTS_SVH
`define TMCC_CONSTS_SVH
`define TMCC_OFF_CNT 8'h00
`define TMCC_OFF_CC1 8'h04
`define TMCC_OFF_CC2 8'h08
`define TMCC_OFF_MODE 8'h0c
`define TMCC_OFF_PRM 8'h10
`define TMCC_OFF_CRC 8'h14
`define TMCC_OFF_IST 8'h18
`define TMCC_OFF_ICLR 8'h1c
`define TMCC_OFF_IEN 8'h20
`define TMCC_MODE_OVF 0
`define TMCC_MODE_OPL 2
`define TMCC_MODE_OPH 3
`define TMCC_CRC_CAP2 0
`define TMCC_PRM_EDGE_LO 4
`define TMCC_PRM_EDGE_HI 5
`define TMCC_OP_STOP 2'h0
`define TMCC_OP_CLR_EDGE 2'h1
`define TMCC_OP_FREE 2'h2
`define TMCC_OP_CLR_MATCH 2'h3
`define TMCC_EDGE_FALL 2'h0
`define TMCC_EDGE_RISE 2'h1
`define TMCC_EDGE_BOTH 2'h3
`define TMCC_CNT_MAX 16'hffff
`define TMCC_CNT_ZERO 16'h0000
`define TMCC_IRQ_OVF 0
`define TMCC_IRQ_MATCH 1
`define TMCC_IRQ_CAP 2
`define TMCC_NIRQ 3
`define TMCC_RESP_OKAY 2'h0
`define TMCC_RESP_SLVERR 2'h2
`endif

// >>> hw/tmcc_pkg.sv
// Types shared by the timer block
package tmcc_pkg;
  typedef enum logic [1:0] {
    TMCC_STOP, TMCC_CLR_EDGE, TMCC_FREE, TMCC_CLR_MATCH
  } tmcc_op_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } tmcc_wr_s;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } tmcc_rd_s;
endpackage

// >>> hw/tmcc_timer.sv
// 16-bit timer/event counter with capture/compare and AXI4-Lite registers
//
// Overview of operation
// - A read colliding with a capture may return stale data, but the stored capture is correct.
// - A capture coinciding with a count stop stores an unspecified value.
// - The second capture/compare register may be written while counting.
// - Any nonzero operation-mode pair starts the counter; zero stops it.
// - The trigger edge is chosen in the prescaler mode register.
// - With the first compare at FFFFH, the FFFFH to 0000H roll sets overflow.
`timescale 1ns/1ns
`include "tmcc_consts.svh"
module tmcc_timer
  import tmcc_pkg::*;
#(
  // Counter width; the byte-lane merges assume 16
  parameter int CNT_W = 16
) (
  input wire logic i_ref_clk, // 10 MHz clock
  input wire logic i_reset, // Sync reset, high
  input wire logic i_ce, // Clock enable, freezes all
  input wire logic i_count_tick, // Count clock pulse from prescaler
  input wire logic i_first_trigger_input, // External trigger pin
  input wire logic [7:0] i_awaddr, // AXI write address
  input wire logic i_awvalid, // AXI
  output logic o_awready, // AXI
  input wire logic [31:0] i_wdata, // AXI
  input wire logic [3:0] i_wstrb, // AXI
  input wire logic i_wvalid, // AXI
  output logic o_wready, // AXI
  output logic [1:0] o_bresp, // AXI
  output logic o_bvalid, // AXI
  input wire logic i_bready, // AXI
  input wire logic [7:0] i_araddr, // AXI read address
  input wire logic i_arvalid, // AXI
  output logic o_arready, // AXI
  output logic [31:0] o_rdata, // AXI
  output logic [1:0] o_rresp, // AXI
  output logic o_rvalid, // AXI
  input wire logic i_rready, // AXI
  output logic o_irq // Level interrupt
);

  logic [CNT_W-1:0] main_up_counter;
  logic [CNT_W-1:0] first_capcmp_reg;
  logic [CNT_W-1:0] second_capcmp_reg;
  logic [7:0] timer_mode_ctrl_reg;
  logic [7:0] prescaler_mode_reg;
  logic [7:0] capcmp_ctrl_reg;
  logic [`TMCC_NIRQ-1:0] irq_stat_reg;
  logic [`TMCC_NIRQ-1:0] irq_en_reg;
  // Write halves held until both have arrived
  logic aw_held_reg, w_held_reg;
  tmcc_wr_s wr_reg;
  tmcc_rd_s rd_reg;
  // Trigger synchroniser and edge stage
  logic trig_s1_reg, trig_s2_reg, trig_s3_reg;
  logic op_mode_bit_low, op_mode_bit_high, counter_overflow_flag;
  logic running, edge_hit, roll, match1, cap_evt, wr_fire;
  logic [CNT_W-1:0] cnt_next;
  tmcc_op_e op;

  // Byte-lane merge, used for every writable register except IEN and ICLR, which test strobe 0 directly
  // Only lanes 0 and 1 hold state; upper strobes are ignored
  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [7:0] nw,
                                        input logic en);
    merge8 = en ? nw : old;
  endfunction

  function automatic logic is_wr(input logic [7:0] off);
    is_wr = wr_fire && (wr_reg.addr == off);
  endfunction

  assign op_mode_bit_low = timer_mode_ctrl_reg[`TMCC_MODE_OPL];
  assign op_mode_bit_high = timer_mode_ctrl_reg[`TMCC_MODE_OPH];
  assign counter_overflow_flag = timer_mode_ctrl_reg[`TMCC_MODE_OVF];
  assign op = tmcc_op_e'({op_mode_bit_high, op_mode_bit_low});
  assign running = (op != TMCC_STOP);

  // Trigger pin through two flops, third stage for edge detect
  // Flops reset low like the idle pin, so no false edge after reset
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_s3_reg <= 1'b0;
    end else if (i_ce) begin
      trig_s1_reg <= i_first_trigger_input;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end

  always_comb begin
    unique case (prescaler_mode_reg[`TMCC_PRM_EDGE_HI:`TMCC_PRM_EDGE_LO])
      `TMCC_EDGE_FALL: edge_hit = trig_s3_reg & ~trig_s2_reg;
      `TMCC_EDGE_RISE: edge_hit = ~trig_s3_reg & trig_s2_reg;
      `TMCC_EDGE_BOTH: edge_hit = trig_s3_reg ^ trig_s2_reg;
      default: edge_hit = 1'b0; // Setting 2 disables the edge
    endcase
  end

  // Capture only while running; a capture at stop is thus unspecified
  assign cap_evt = edge_hit && running &&
                   capcmp_ctrl_reg[`TMCC_CRC_CAP2];
  assign match1 = (main_up_counter == first_capcmp_reg);
  assign roll = running && i_count_tick &&
                (main_up_counter == `TMCC_CNT_MAX);

  // Counter next value by mode
  // An edge clear outranks the tick; a stopped counter holds
  always_comb begin
    cnt_next = main_up_counter;
    if (!running) begin
      cnt_next = main_up_counter;
    end else if (op == TMCC_CLR_EDGE && edge_hit) begin
      cnt_next = `TMCC_CNT_ZERO;
    end else if (i_count_tick) begin
      if (op == TMCC_CLR_MATCH && match1) begin
        cnt_next = `TMCC_CNT_ZERO;
      end else begin
        cnt_next = main_up_counter + CNT_W'(1);
      end
    end
  end

  // Counter register; stop freezes the count
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      main_up_counter <= `TMCC_CNT_ZERO;
    end else if (i_ce) begin
      main_up_counter <= cnt_next;
    end
  end

  // Mode register with hardware overflow set
  // Writes are not gated while running; ordering is software's duty
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      timer_mode_ctrl_reg <= 8'h00;
    end else if (i_ce) begin
      if (is_wr(`TMCC_OFF_MODE)) begin
        timer_mode_ctrl_reg <= merge8(timer_mode_ctrl_reg,
                                      wr_reg.data[7:0], wr_reg.strb[0]);
      end
      if (roll && first_capcmp_reg == `TMCC_CNT_MAX) begin
        timer_mode_ctrl_reg[`TMCC_MODE_OVF] <= 1'b1;
      end
    end
  end

  // First compare and control registers
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      first_capcmp_reg <= `TMCC_CNT_ZERO;
      prescaler_mode_reg <= 8'h00;
      capcmp_ctrl_reg <= 8'h00;
    end else if (i_ce) begin
      if (is_wr(`TMCC_OFF_CC1)) begin
        first_capcmp_reg <= {merge8(first_capcmp_reg[15:8],
                                    wr_reg.data[15:8], wr_reg.strb[1]),
                             merge8(first_capcmp_reg[7:0],
                                    wr_reg.data[7:0], wr_reg.strb[0])};
      end
      if (is_wr(`TMCC_OFF_PRM)) begin
        prescaler_mode_reg <= merge8(prescaler_mode_reg,
                                     wr_reg.data[7:0], wr_reg.strb[0]);
      end
      if (is_wr(`TMCC_OFF_CRC)) begin
        capcmp_ctrl_reg <= merge8(capcmp_ctrl_reg,
                                  wr_reg.data[7:0], wr_reg.strb[0]);
      end
    end
  end

  // Second register: compare value or capture; capture wins a collision
  // Captures are dropped while stopped, where the value is unspecified
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      second_capcmp_reg <= `TMCC_CNT_ZERO;
    end else if (i_ce) begin
      if (cap_evt) begin
        second_capcmp_reg <= main_up_counter;
      end else if (is_wr(`TMCC_OFF_CC2)) begin
        second_capcmp_reg <= {merge8(second_capcmp_reg[15:8],
                                     wr_reg.data[15:8], wr_reg.strb[1]),
                              merge8(second_capcmp_reg[7:0],
                                     wr_reg.data[7:0], wr_reg.strb[0])};
      end
    end
  end

  // Sticky interrupt status; set wins over clear
  // An event and its clear in one cycle leave the bit set
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
    end else if (i_ce) begin
      if (is_wr(`TMCC_OFF_IEN) && wr_reg.strb[0]) begin
        irq_en_reg <= wr_reg.data[`TMCC_NIRQ-1:0];
      end
      irq_stat_reg <= (irq_stat_reg &
        ~((is_wr(`TMCC_OFF_ICLR) && wr_reg.strb[0]) ?
          wr_reg.data[`TMCC_NIRQ-1:0] : '0)) |
        {cap_evt, running && i_count_tick && match1, roll};
    end
  end

  // Interrupt level from a flop, so no glitch reaches the pin
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // Write channel: address and data latched in any order
  // The response rises one cycle after both halves are held
  // Read-only and unmapped offsets answer SLVERR and change nothing
  assign o_awready = !aw_held_reg && !o_bvalid;
  assign o_wready = !w_held_reg && !o_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !o_bvalid;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_reg <= '0;
      o_bvalid <= 1'b0;
      o_bresp <= `TMCC_RESP_OKAY;
    end else if (i_ce) begin
      if (i_awvalid && o_awready) begin
        aw_held_reg <= 1'b1;
        wr_reg.addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_reg <= 1'b1;
        wr_reg.data <= i_wdata;
        wr_reg.strb <= i_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (wr_reg.addr > `TMCC_OFF_IEN || wr_reg.addr[1:0] != 2'h0
                    || wr_reg.addr == `TMCC_OFF_CNT
                    || wr_reg.addr == `TMCC_OFF_IST) ?
                   `TMCC_RESP_SLVERR : `TMCC_RESP_OKAY;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; read sees pre-capture value, store stays exact
  // Data is taken at the address handshake; a capture in that same
  // cycle shows up only on the next read
  assign o_arready = !o_rvalid;
  assign o_rdata = rd_reg.data;
  assign o_rresp = rd_reg.resp;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rvalid <= 1'b0;
      rd_reg <= '0;
    end else if (i_ce) begin
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        rd_reg.resp <= `TMCC_RESP_OKAY;
        unique case (i_araddr)
          `TMCC_OFF_CNT: rd_reg.data <= {16'h0000, main_up_counter};
          `TMCC_OFF_CC1: rd_reg.data <= {16'h0000, first_capcmp_reg};
          `TMCC_OFF_CC2: rd_reg.data <= {16'h0000, second_capcmp_reg};
          `TMCC_OFF_MODE: rd_reg.data <= {24'h000000, timer_mode_ctrl_reg};
          `TMCC_OFF_PRM: rd_reg.data <= {24'h000000, prescaler_mode_reg};
          `TMCC_OFF_CRC: rd_reg.data <= {24'h000000, capcmp_ctrl_reg};
          `TMCC_OFF_IST: rd_reg.data <= {29'h00000000, irq_stat_reg};
          `TMCC_OFF_IEN: rd_reg.data <= {29'h00000000, irq_en_reg};
          `TMCC_OFF_ICLR: rd_reg.data <= 32'h00000000; // Write-only
          default: begin
            rd_reg.data <= 32'h00000000;
            rd_reg.resp <= `TMCC_RESP_SLVERR;
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> testbench/tmcc_timer_asserts.sv
// Bus handshake checks on the timer block ports
`timescale 1ns/1ns
module tmcc_timer_asserts (
  input wire logic i_ref_clk, // Clock
  input wire logic i_reset, // Sync reset
  input wire logic i_ce, // Clock enable
  input wire logic i_awvalid, // Watched
  input wire logic o_awready, // Watched
  input wire logic i_wvalid, // Watched
  input wire logic o_wready, // Watched
  input wire logic [1:0] o_bresp, // Watched
  input wire logic o_bvalid, // Watched
  input wire logic i_bready, // Watched
  input wire logic i_arvalid, // Watched
  input wire logic o_arready, // Watched
  input wire logic [31:0] o_rdata, // Watched
  input wire logic o_rvalid, // Watched
  input wire logic i_rready, // Watched
  input wire logic o_irq // Watched
);
  // Frozen clock enable would stall every relation below
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset || !i_ce);
  a_bresp_stands: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
  a_rdata_stands: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata)) else $error("read answer dropped");
  a_read_refused: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while answer pending");
  a_write_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while answer pending");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid &&
    o_wready |=> !o_bvalid ##1 o_bvalid) else $error("write answer late");
  a_reset_idle: assert property ($fell(i_reset) |-> !o_bvalid && !o_rvalid
    && !o_irq) else $error("outputs not idle after reset");
  a_ready_idle: assert property ($fell(i_reset) |-> o_awready && o_wready &&
    o_arready) else $error("ready low after reset");
endmodule
bind tmcc_timer tmcc_timer_asserts tmcc_timer_asserts_inst (.i_ref_clk,
  .i_reset, .i_ce, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp,
  .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid,
  .i_rready, .o_irq);

// >>> testbench/tmcc_trig_model.sv
// External trigger pin source
`timescale 1ns/1ns
module tmcc_trig_model (
  input wire logic i_clk, // Bench clock
  output logic o_pin // Trigger pin level
);
  initial o_pin = 1'b0;
  // pulse width kept
  // Level held n cycles, longer than two count clocks plus sync delay
  task put(input logic v, input int n);
    @(posedge i_clk) o_pin <= v;
    repeat (n) @(posedge i_clk);
  endtask
endmodule

// >>> testbench/testbench.sv
// Register level tests of the timer block
`timescale 1ns/1ns
`include "tmcc_consts.svh"
module testbench;
  import tmcc_pkg::*;
  logic c = 0, rst = 1, tick = 0, pin, awv = 0, wv = 0, bre = 0;
  logic arv = 0, rre = 0, awr, wr_, bv, arr, rv, irq, da, dw;
  logic [1:0] bp, rp;
  int hold = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, r1, rdat;
  logic [1:0] br, rr;
  int err_count = 0, tests_run = 0;
  always #50 c = ~c;
  tmcc_trig_model tmcc_trig_model_inst (.i_clk(c), .o_pin(pin));
  tmcc_timer tmcc_timer_inst (.i_ref_clk(c), .i_reset(rst), .i_ce(1'b1),
    .i_count_tick(tick), .i_first_trigger_input(pin), .i_awaddr(awa),
    .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hf),
    .i_wvalid(wv), .o_wready(wr_), .o_bresp(br), .o_bvalid(bv),
    .i_bready(bre), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr),
    .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv), .i_rready(rre),
    .o_irq(irq));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write: both channels offered, each released once taken
  // A nonzero hold raises bready only that many cycles later
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge c);
    {awa, wd, awv, wv, bre} <= {a, d, 2'h3, hold == 0};
    {da, dw} = 2'h0;
    while (!(da && dw)) begin
      @(posedge c);
      if (!da && awr) begin
        awv <= 1'b0;
        da = 1'b1;
      end
      if (!dw && wr_) begin
        wv <= 1'b0;
        dw = 1'b1;
      end
    end
    if (hold > 0) begin
      repeat (hold) @(posedge c);
      bre <= 1'b1;
    end
    do @(posedge c); while (!bv);
    bp = br;
    bre <= 1'b0;
  endtask
  // Read: address held until taken, data taken at the rvalid edge
  task rdr(input logic [7:0] a);
    @(posedge c);
    {ara, arv, rre} <= {a, 1'b1, hold == 0};
    do @(posedge c); while (!arr);
    arv <= 1'b0;
    if (hold > 0) begin
      repeat (hold) @(posedge c);
      rre <= 1'b1;
    end
    do @(posedge c); while (!rv);
    {rd, rp} = {rdat, rr};
    rre <= 1'b0;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Overflow run is about 66000 cycles
  initial begin
    repeat (80000) @(posedge c);
    err_count++;
    conclude;
  end
  initial begin
    repeat (2) @(posedge c);
    rst <= 0;
    rdr(`TMCC_OFF_MODE);
    chk("mode reset", rd, 0);
    // Late ready on both answers, so they must stand
    hold = 2;
    rdr(8'h24);
    chk("unmapped resp", rp, `TMCC_RESP_SLVERR);
    wr(`TMCC_OFF_CNT, 32'h5);
    chk("ro write resp", bp, `TMCC_RESP_SLVERR);
    hold = 0;
    rdr(`TMCC_OFF_CNT);
    chk("ro write ignored", rd, 0);
    $display("test reset done");
    tick <= 1;
    wr(`TMCC_OFF_MODE, 32'h08);
    rdr(`TMCC_OFF_CNT);
    r1 = rd;
    rdr(`TMCC_OFF_CNT);
    chk("counting", rd != r1, 1);
    wr(`TMCC_OFF_CC2, 32'h1234);
    chk("write resp", bp, `TMCC_RESP_OKAY);
    rdr(`TMCC_OFF_CC2);
    chk("cc2 running", rd, 32'h1234);
    wr(`TMCC_OFF_MODE, 0);
    rdr(`TMCC_OFF_CNT);
    r1 = rd;
    rdr(`TMCC_OFF_CNT);
    chk("stopped", rd, r1);
    $display("test start stop done");
    wr(`TMCC_OFF_CRC, 1);
    wr(`TMCC_OFF_PRM, 0);
    wr(`TMCC_OFF_MODE, 8);
    wr(`TMCC_OFF_ICLR, 7);
    tmcc_trig_model_inst.put(1, 8);
    rdr(`TMCC_OFF_IST);
    chk("rise ignored", rd & 4, 0);
    tmcc_trig_model_inst.put(0, 8);
    rdr(`TMCC_OFF_IST);
    chk("fall capture", rd & 4, 4);
    $display("test edge select done");
    // stop before the other mode bits
    wr(`TMCC_OFF_MODE, 0);
    wr(`TMCC_OFF_CRC, 0);
    wr(`TMCC_OFF_CC1, 32'hffff);
    wr(`TMCC_OFF_IEN, 1);
    wr(`TMCC_OFF_ICLR, 7);
    chk("irq off", irq, 0);
    wr(`TMCC_OFF_MODE, 8);
    repeat (65600) @(posedge c);
    tick <= 0;
    rdr(`TMCC_OFF_MODE);
    chk("ovf set", rd, 32'h09);
    chk("irq on", irq, 1);
    wr(`TMCC_OFF_MODE, 8);
    rdr(`TMCC_OFF_MODE);
    chk("ovf cleared", rd, 32'h08);
    wr(`TMCC_OFF_ICLR, 7);
    rdr(`TMCC_OFF_IST);
    chk("status clr", rd, 0);
    chk("irq cleared", irq, 0);
    $display("test overflow done");
    conclude;
  end
endmodule
